//--- logic/mibi_consts.svh
`ifndef MIBI_CONSTS_SVH
`define MIBI_CONSTS_SVH
// Register indices on APB (byte address is index times four)
`define MIBI_IDX_BUS_REQ 16'h7f70
`define MIBI_IDX_IO_BASE 16'h7f71
`define MIBI_IDX_MEM_BASE 16'h7f72
`define MIBI_IDX_STAT 16'h7f73
`define MIBI_IDX_MASK 16'h7f74
`define MIBI_IDX_IRQ 16'h7f75
`define MIBI_ADDR_W 18
// Field positions in the bus request register
`define MIBI_BIT_INH_HI 7
`define MIBI_BIT_INH_LO 4
`define MIBI_BIT_DMA_RST 3
`define MIBI_BIT_AEN 2
`define MIBI_BIT_HOLD_ACKNOWLEDGE 1
`define MIBI_BIT_HOLD_REQUEST 0
// Reset values
`define MIBI_RST_BUS_REQ 8'h00
`define MIBI_RST_IO_BASE 8'h00
`define MIBI_RST_MEM_BASE 8'h00
`define MIBI_RST_MASK 8'hff
`endif

//--- logic/mibi_pkg.sv
package mibi_pkg;
  typedef logic [7:0] mibi_byte_t;
  typedef enum logic [1:0] {
    MIBI_CYC_NONE,
    MIBI_CYC_IO,
    MIBI_CYC_MEM
  } mibi_cyc_e;
endpackage : mibi_pkg

//--- logic/mibi_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mibi_sync_if;
  logic [7:0] raw;
  logic [7:0] synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface : mibi_sync_if
`default_nettype wire

//--- logic/mibi_sync.sv
`timescale 1ns/1ps
`default_nettype none
module mibi_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus of levels to resynchronise
  mibi_sync_if.dst s
);
  logic [7:0] meta_q;
  logic [7:0] meta_d;
  logic [7:0] sync_q;
  logic [7:0] sync_d;

  always_comb begin
    meta_d = s.raw;
    sync_d = meta_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign s.synced = sync_q;
endmodule : mibi_sync
`default_nettype wire

//--- logic/mibi_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mibi_consts.svh"
module mibi_top (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // DMA controller side
  input wire logic [3:0] dma_tc_raw,
  input wire logic dma_mem_to_mem,
  input wire logic [7:0] dma_internal_status,
  input wire logic dma_aen,
  input wire logic dma_hold_request,
  output logic dma_reset,
  output logic hold_acknowledge,
  output logic [3:0] dma_eop,
  // Microcontroller window requests (same clock)
  input wire logic mcu_io_req,
  input wire logic mcu_mem_req,
  input wire logic mcu_write,
  input wire logic [11:0] mcu_offset,
  input wire logic [7:0] mcu_wdata,
  // ISA bus drive
  output logic [19:0] isa_sa,
  output logic isa_sa_oen,
  output logic isa_ior,
  output logic isa_iow,
  output logic isa_memr,
  output logic isa_memw,
  output logic isa_cmd_oen,
  output logic [7:0] isa_sd_out,
  output logic isa_sd_oen,
  output logic isa_dma_interrupt_flag
);
  import mibi_pkg::*;

  localparam logic [`MIBI_ADDR_W-1:0] A_BUS_REQ = `MIBI_ADDR_W'(`MIBI_IDX_BUS_REQ * 4);
  localparam logic [`MIBI_ADDR_W-1:0] A_IO_BASE = `MIBI_ADDR_W'(`MIBI_IDX_IO_BASE * 4);
  localparam logic [`MIBI_ADDR_W-1:0] A_MEM_BASE = `MIBI_ADDR_W'(`MIBI_IDX_MEM_BASE * 4);
  localparam logic [`MIBI_ADDR_W-1:0] A_STAT = `MIBI_ADDR_W'(`MIBI_IDX_STAT * 4);
  localparam logic [`MIBI_ADDR_W-1:0] A_MASK = `MIBI_ADDR_W'(`MIBI_IDX_MASK * 4);
  localparam logic [`MIBI_ADDR_W-1:0] A_IRQ = `MIBI_ADDR_W'(`MIBI_IDX_IRQ * 4);

  // Status comes from the DMA clock domain, so it is resynchronised
  mibi_sync_if stat_if ();
  mibi_sync_if ctl_if ();
  mibi_byte_t stat_s;
  logic aen_s;
  logic hold_request_s;

  assign stat_if.raw = dma_internal_status;
  assign ctl_if.raw = {6'b00_0000, dma_aen, dma_hold_request};

  mibi_sync u_stat_sync (
    .pclk(pclk),
    .presetn(presetn),
    .s(stat_if.dst)
  );

  mibi_sync u_ctl_sync (
    .pclk(pclk),
    .presetn(presetn),
    .s(ctl_if.dst)
  );

  assign stat_s = stat_if.synced;
  assign aen_s = ctl_if.synced[1];
  assign hold_request_s = ctl_if.synced[0];

  // Register state
  logic [3:0] inh_q, inh_d;
  logic rst_q, rst_d;
  logic hold_acknowledge_q, hold_acknowledge_d;
  mibi_byte_t io_base_q, io_base_d;
  mibi_byte_t mem_base_q, mem_base_d;
  mibi_byte_t mask_q, mask_d;
  mibi_byte_t stat_prev_q, stat_prev_d;
  logic flag_q, flag_d;
  logic [31:0] prdata_q, prdata_d;

  logic [`MIBI_ADDR_W-1:0] addr;
  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic [7:0] rise;

  assign addr = paddr[`MIBI_ADDR_W-1:0];
  // Writes land only at the edge that completes the transfer
  assign wr_acc = psel & penable & pwrite & pready;
  assign rd_acc = psel & penable & ~pwrite;
  assign hit = (addr == A_BUS_REQ) | (addr == A_IO_BASE) | (addr == A_MEM_BASE) |
               (addr == A_STAT) | (addr == A_MASK) | (addr == A_IRQ);
  assign rise = stat_s & ~stat_prev_q & ~mask_q;

  always_comb begin
    inh_d = inh_q;
    rst_d = rst_q;
    hold_acknowledge_d = hold_acknowledge_q;
    io_base_d = io_base_q;
    mem_base_d = mem_base_q;
    mask_d = mask_q;
    stat_prev_d = stat_s;
    flag_d = flag_q;
    prdata_d = prdata_q;
    // Write-one-to-clear, but a new edge in the same cycle keeps it set
    if (wr_acc && addr == A_IRQ && pwdata[0]) begin
      flag_d = 1'b0;
    end
    if (|rise) begin
      flag_d = 1'b1;
    end
    if (wr_acc) begin
      case (addr)
        A_BUS_REQ: begin
          inh_d = pwdata[`MIBI_BIT_INH_HI:`MIBI_BIT_INH_LO];
          rst_d = pwdata[`MIBI_BIT_DMA_RST];
          hold_acknowledge_d = pwdata[`MIBI_BIT_HOLD_ACKNOWLEDGE];
        end
        A_IO_BASE: io_base_d = pwdata[7:0];
        A_MEM_BASE: mem_base_d = pwdata[7:0];
        A_MASK: mask_d = pwdata[7:0];
        default: ;
      endcase
    end
    if (rd_acc) begin
      case (addr)
        A_BUS_REQ: prdata_d = {24'h00_0000, inh_q, rst_q, aen_s, hold_acknowledge_q, hold_request_s};
        A_IO_BASE: prdata_d = {24'h00_0000, io_base_q};
        A_MEM_BASE: prdata_d = {24'h00_0000, mem_base_q};
        A_STAT: prdata_d = {24'h00_0000, stat_s};
        A_MASK: prdata_d = {24'h00_0000, mask_q};
        A_IRQ: prdata_d = {31'h0000_0000, flag_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inh_q <= 4'h0;
      rst_q <= 1'b0;
      hold_acknowledge_q <= 1'b0;
      io_base_q <= `MIBI_RST_IO_BASE;
      mem_base_q <= `MIBI_RST_MEM_BASE;
      mask_q <= `MIBI_RST_MASK;
      stat_prev_q <= 8'h00;
      flag_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      inh_q <= inh_d;
      rst_q <= rst_d;
      hold_acknowledge_q <= hold_acknowledge_d;
      io_base_q <= io_base_d;
      mem_base_q <= mem_base_d;
      mask_q <= mask_d;
      stat_prev_q <= stat_prev_d;
      flag_q <= flag_d;
      prdata_q <= prdata_d;
    end
  end

  // One-wait-state APB: read data is registered during the setup cycle's follow-on
  // access phase, so the access phase lasts two cycles for reads and writes alike
  logic acc_wait_q, acc_wait_d;
  always_comb begin
    acc_wait_d = psel & penable & ~acc_wait_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_wait_q <= 1'b0;
    end else begin
      acc_wait_q <= acc_wait_d;
    end
  end
  assign pready = acc_wait_q;
  assign pslverr = acc_wait_q & ~hit;
  assign prdata = prdata_q;

  // DMA controls
  assign dma_reset = rst_q;
  assign hold_acknowledge = hold_acknowledge_q;
  // Memory-to-memory transfers pass terminal count unmasked
  assign dma_eop = dma_mem_to_mem ? dma_tc_raw : (dma_tc_raw & ~inh_q);
  assign isa_dma_interrupt_flag = flag_q;

  // Window cycle drive, registered so the ISA pins change cleanly
  mibi_cyc_e cyc_q, cyc_d;
  logic [19:0] sa_q, sa_d;
  logic wr_q, wr_d;
  logic [7:0] sd_q, sd_d;

  always_comb begin
    cyc_d = MIBI_CYC_NONE;
    sa_d = sa_q;
    wr_d = wr_q;
    sd_d = sd_q;
    // Granted bus belongs to the DMA controller; window cycles are held off
    if (!hold_acknowledge_q) begin
      if (mcu_io_req) begin
        cyc_d = MIBI_CYC_IO;
        sa_d = {4'h0, io_base_q, mcu_offset[7:0]};
        wr_d = mcu_write;
        sd_d = mcu_wdata;
      end else if (mcu_mem_req) begin
        cyc_d = MIBI_CYC_MEM;
        sa_d = {mem_base_q, mcu_offset};
        wr_d = mcu_write;
        sd_d = mcu_wdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_q <= MIBI_CYC_NONE;
      sa_q <= 20'h0_0000;
      wr_q <= 1'b0;
      sd_q <= 8'h00;
    end else begin
      cyc_q <= cyc_d;
      sa_q <= sa_d;
      wr_q <= wr_d;
      sd_q <= sd_d;
    end
  end

  logic drive;
  always_comb begin
    case (cyc_q)
      MIBI_CYC_IO: drive = 1'b1;
      MIBI_CYC_MEM: drive = 1'b1;
      default: drive = 1'b0;
    endcase
  end

  assign isa_sa = sa_q;
  // Enables are low while driving; grant forces release of shared pins
  assign isa_sa_oen = ~(drive & ~hold_acknowledge_q);
  assign isa_cmd_oen = hold_acknowledge_q;
  assign isa_sd_oen = ~(drive & wr_q & ~hold_acknowledge_q);
  assign isa_sd_out = sd_q;
  assign isa_ior = (cyc_q == MIBI_CYC_IO) & ~wr_q & ~hold_acknowledge_q;
  assign isa_iow = (cyc_q == MIBI_CYC_IO) & wr_q & ~hold_acknowledge_q;
  assign isa_memr = (cyc_q == MIBI_CYC_MEM) & ~wr_q & ~hold_acknowledge_q;
  assign isa_memw = (cyc_q == MIBI_CYC_MEM) & wr_q & ~hold_acknowledge_q;
endmodule : mibi_top
`default_nettype wire

//--- tb/mibi_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mibi_top_properties (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  // DMA side
  input wire logic [3:0] dma_tc_raw,
  input wire logic dma_mem_to_mem,
  input wire logic [3:0] dma_eop,
  input wire logic dma_reset,
  input wire logic hold_acknowledge,
  // Window and bus
  input wire logic mcu_io_req,
  input wire logic [11:0] mcu_offset,
  input wire logic [19:0] isa_sa,
  input wire logic isa_ior,
  input wire logic isa_iow,
  input wire logic isa_memr,
  input wire logic isa_memw,
  input wire logic isa_cmd_oen,
  input wire logic isa_dma_interrupt_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic apb_wr;
  assign apb_wr = psel && penable && pready && pwrite;
  sequence s_io_take;
    mcu_io_req && !hold_acknowledge;
  endsequence
  a_eop_inhibit: assert property (
    (dma_eop & ~dma_tc_raw) == 4'h0) else $error("eop without count");
  a_eop_m2m: assert property (
    dma_mem_to_mem |-> dma_eop == dma_tc_raw) else $error("eop inhibited in m2m");
  a_grant_tristate: assert property (
    hold_acknowledge |-> isa_cmd_oen && !(isa_ior || isa_iow || isa_memr || isa_memw))
    else $error("bus driven while granted");
  a_io_strobe: assert property (
    s_io_take ##1 s_io_take |-> isa_ior || isa_iow) else $error("io cycle missing");
  a_io_offset: assert property (
    isa_ior || isa_iow |-> isa_sa[7:0] == $past(mcu_offset[7:0])) else $error("io offset");
  a_mem_offset: assert property (
    isa_memr || isa_memw |-> isa_sa[11:0] == $past(mcu_offset)) else $error("mem offset");
  a_flag_sticky: assert property (
    $fell(isa_dma_interrupt_flag) |-> $past(apb_wr)) else $error("flag cleared itself");
  a_reset_write: assert property (
    $changed(dma_reset) |-> $past(apb_wr)) else $error("dma reset moved alone");
  a_apb_answer: assert property (
    psel && $rose(penable) |=> pready) else $error("pready late");
endmodule : mibi_top_properties
bind mibi_top mibi_top_properties mibi_top_properties_i (.*);
`default_nettype wire

//--- tb/mibi_dma_model.sv
`timescale 1ns/1ps
`default_nettype none
module mibi_dma_model (
  // Device side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dma_reset,
  input wire logic hold_acknowledge,
  input wire logic isa_ior,
  input wire logic [19:0] isa_sa,
  // Bench controls
  input wire logic [3:0] req_ctl,
  input wire logic [3:0] tc_ctl,
  // Controller pins
  output logic [3:0] dma_tc_raw,
  output logic [7:0] dma_internal_status,
  output logic dma_aen,
  output logic dma_hold_request
);
  logic [3:0] tc_q;
  assign dma_tc_raw = tc_ctl;
  assign dma_hold_request = |req_ctl && !dma_reset;
  assign dma_internal_status = {req_ctl, tc_q};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_q <= 4'h0;
      dma_aen <= 1'b0;
    end else begin
      dma_aen <= hold_acknowledge && dma_hold_request;
      if (dma_reset) begin
        tc_q <= 4'h0;
      end else if (isa_ior && isa_sa[3:0] == 4'h8) begin
        tc_q <= 4'h0;
      end else begin
        tc_q <= tc_q | tc_ctl;
      end
    end
  end
endmodule : mibi_dma_model
`default_nettype wire

//--- tb/test_mibi_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mibi_consts.svh"
module test_mibi_top;
  localparam logic [31:0] ad_req = 32'(`MIBI_IDX_BUS_REQ) << 2;
  localparam logic [31:0] ad_io = 32'(`MIBI_IDX_IO_BASE) << 2;
  localparam logic [31:0] ad_mem = 32'(`MIBI_IDX_MEM_BASE) << 2;
  localparam logic [31:0] ad_stat = 32'(`MIBI_IDX_STAT) << 2;
  localparam logic [31:0] ad_mask = 32'(`MIBI_IDX_MASK) << 2;
  localparam logic [31:0] ad_irq = 32'(`MIBI_IDX_IRQ) << 2;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, flag;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic dma_mem_to_mem, dma_reset, hold_acknowledge, dma_aen, dma_hold_request;
  logic [3:0] dma_tc_raw, dma_eop, req_ctl, tc_ctl;
  logic [7:0] dma_internal_status, mcu_wdata, isa_sd_out;
  logic mcu_io_req, mcu_mem_req, mcu_write, isa_sa_oen, isa_ior, isa_iow;
  logic isa_memr, isa_memw, isa_cmd_oen, isa_sd_oen;
  logic [11:0] mcu_offset;
  logic [19:0] isa_sa;
  int miscompares = 0;
  int total_checks = 0;
  mibi_top mibi_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .dma_tc_raw, .dma_mem_to_mem, .dma_internal_status,
    .dma_aen, .dma_hold_request, .dma_reset, .hold_acknowledge, .dma_eop, .mcu_io_req,
    .mcu_mem_req, .mcu_write, .mcu_offset, .mcu_wdata, .isa_sa, .isa_sa_oen, .isa_ior,
    .isa_iow, .isa_memr, .isa_memw, .isa_cmd_oen, .isa_sd_out, .isa_sd_oen,
    .isa_dma_interrupt_flag(flag));
  mibi_dma_model mibi_dma_model_i (.pclk, .presetn, .dma_reset, .hold_acknowledge,
    .isa_ior, .isa_sa, .req_ctl, .tc_ctl, .dma_tc_raw, .dma_internal_status, .dma_aen,
    .dma_hold_request);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Request held until the rising edge that samples pready high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input string n, input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, rd, e);
  endtask : rd_chk
  initial begin
    {psel, penable, pwrite, dma_mem_to_mem, mcu_io_req, mcu_mem_req, mcu_write} = '0;
    {paddr, pwdata} = '0;
    {req_ctl, tc_ctl, mcu_wdata, mcu_offset} = '0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("io_base", ad_io, 8'h00);
    rd_chk("mem_base", ad_mem, 8'h00);
    rd_chk("mask", ad_mask, 8'hff);
    wr(ad_req, 8'h05);
    rd_chk("req_ro", ad_req, 8'h00);
    apb(1'b0, 32'h0000_0100, 32'h0000_0000);
    chk("slverr", 32'(err), 8'h01);
    wr(ad_req, 8'h08);
    @(negedge pclk);
    chk("dma_reset", 32'(dma_reset), 8'h01);
    wr(ad_req, 8'h00);
    @(negedge pclk);
    chk("dma_run", 32'(dma_reset), 8'h00);
    @(posedge pclk);
    req_ctl <= 4'h1;
    repeat (3) @(posedge pclk);
    rd_chk("hold_request", ad_req, 8'h01);
    wr(ad_req, 8'h02);
    repeat (3) @(posedge pclk);
    rd_chk("grant", ad_req, 8'h07);
    mcu_io_req <= 1'b1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("granted_bus", 32'({isa_ior, isa_cmd_oen}), 8'h01);
    @(posedge pclk);
    mcu_io_req <= 1'b0;
    req_ctl <= 4'h0;
    wr(ad_req, 8'h00);
    // Let the controller finish its transfer before using the bus
    repeat (4) @(posedge pclk);
    wr(ad_io, 8'h12);
    wr(ad_mem, 8'hab);
    mcu_offset <= 12'h034;
    mcu_io_req <= 1'b1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("io_sa", 32'(isa_sa), 20'h0_1234);
    chk("io_cyc", 32'({isa_ior, isa_sa_oen}), 8'h02);
    @(posedge pclk);
    mcu_io_req <= 1'b0;
    mcu_mem_req <= 1'b1;
    mcu_write <= 1'b1;
    mcu_offset <= 12'hcde;
    mcu_wdata <= 8'h5a;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("mem_sa", 32'(isa_sa), 20'ha_bcde);
    chk("mem_cyc", 32'({isa_memw, isa_sd_out, isa_sd_oen}), 12'h2b4);
    @(posedge pclk);
    mcu_mem_req <= 1'b0;
    mcu_write <= 1'b0;
    tc_ctl <= 4'hf;
    for (int c = 0; c < 4; c++) begin
      wr(ad_req, 32'(16 << c));
      @(negedge pclk);
      chk("eop", 32'(dma_eop), 32'(4'hf ^ (4'h1 << c)));
    end
    @(posedge pclk);
    dma_mem_to_mem <= 1'b1;
    @(negedge pclk);
    chk("eop_m2m", 32'(dma_eop), 8'h0f);
    @(posedge pclk);
    dma_mem_to_mem <= 1'b0;
    tc_ctl <= 4'h0;
    rd_chk("stat_tc", ad_stat, 8'h0f);
    rd_chk("stat_again", ad_stat, 8'h0f);
    chk("masked", 32'(flag), 8'h00);
    mcu_offset <= 12'h008;
    mcu_io_req <= 1'b1;
    @(posedge pclk);
    mcu_io_req <= 1'b0;
    // Clear reaches the controller, then two synchroniser stages
    repeat (3) @(posedge pclk);
    rd_chk("stat_clr", ad_stat, 8'h00);
    wr(ad_mask, 8'hef);
    req_ctl <= 4'h1;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk("flag_set", 32'(flag), 8'h01);
    rd_chk("stat_req", ad_stat, 8'h10);
    req_ctl <= 4'h0;
    repeat (4) @(posedge pclk);
    rd_chk("irq", ad_irq, 8'h01);
    wr(ad_irq, 8'h01);
    @(negedge pclk);
    chk("flag_clr", 32'(flag), 8'h00);
    @(posedge pclk);
    req_ctl <= 4'h2;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk("flag_masked", 32'(flag), 8'h00);
    tally_and_finish();
  end
endmodule : test_mibi_top
`default_nettype wire
